// [logic/spd_core.sv]
// Purpose: Serial-programmed synthesizer core: shift register, setting latch,
//          reference and programmable dividers, phase/frequency detector
// Assumes: All pins are asynchronous to pclk and slow against 200 MHz
// Notes:   APB slave answers with pready one cycle after setup
//
// Operation
// - each rising serial clock edge shifts one data bit into the register; the core shifts only while ser_en_r is set
// - shift register is fourteen bits, one whole setting word
// - latch strobe high copies shift register into the setting latch
// - swallow count is five-bit binary, values 0 to 31
// - main count is nine-bit binary; host loads only 32 to 511
// - both counts straight binary, lowest bit least significant
// - reference counter divides the oscillator rate by fixed 512
// - prescaler divides by 512 or 528, swallow counter picks modulus
// - total division equals 512 times main plus 16 times swallow
// - select high: up drives high, down low, equal Z; select low swaps
// - monitor shows reference divider if select high, else programmable divider
// - polarity select pulled up, an open input acts high
// - lock indicator high normally, low while a phase difference exists
// - phase detector resolves minus two pi to plus two pi
// - at zero error short spikes appear on pump outputs, no dead band
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module spd_core (
   // APB clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial programming pins
   input  wire logic        serial_clk_in,
   input  wire logic        serial_data_in,
   input  wire logic        latch_transfer_strobe,
   // Rate inputs
   input  wire logic        vco_in,
   input  wire logic        osc_in,
   // Polarity select pin and its board-drive indication
   input  wire logic        phase_polarity_select,
   input  wire logic        phase_polarity_select_drv,
   // Charge pump outputs (value and enable)
   output logic             charge_pump_out_one,
   output logic             charge_pump_out_one_oe,
   output logic             charge_pump_out_two,
   output logic             charge_pump_out_two_oe,
   // Status outputs
   output logic             lock_indicator,
   output logic             monitor_out
);

   // ==========================================================================
   // Declarations
   logic [spd_pkg::PIN_N-1:0]   pin_meta_r;
   logic [spd_pkg::PIN_N-1:0]   pin_sync_r;
   logic [spd_pkg::PIN_N-1:0]   pin_prev_r;
   logic [spd_pkg::PIN_N-1:0]   pin_rise;
   // Idle pin levels: the open select pin reads high, so no false low after reset
   localparam logic [spd_pkg::PIN_N-1:0] PIN_IDLE = {{(spd_pkg::PIN_N-1){1'b0}}, 1'b1}
                                                    << spd_pkg::PIN_POL;
   logic                        pol_raw;

   logic [spd_pkg::WORD_W-1:0]  shift_r;
   logic [spd_pkg::WORD_W-1:0]  latch_r;
   logic [spd_pkg::WORD_W-1:0]  setword_r;
   logic                        ser_en_r;
   logic                        pol_r;

   logic [spd_pkg::MAIN_W-1:0]    main_count_bits;
   logic [spd_pkg::SWALLOW_W-1:0] swallow_count_bits;

   logic                        reference_compare_rate;
   logic                        vco_compare_rate;

   logic                        up_r;
   logic                        dn_r;
   logic [spd_pkg::ABL_W-1:0]   abl_cnt_r;
   logic                        up_set;
   logic                        dn_set;
   logic                        abl_start;
   logic                        abl_active;
   logic                        cp_drive;
   logic                        cp_level;
   logic                        cp_out_r;
   logic                        cp_oe_r;
   logic                        lock_r;
   logic                        mon_r;

   logic                        setup_ph;
   logic                        access_ph;
   logic                        wr_access;
   logic                        addr_hit;
   logic                        sel_ctrl;
   logic                        sel_setword;
   logic                        sel_shift;
   logic                        sel_latch;
   logic                        sel_status;
   logic                        sw_load;
   logic [31:0]                 rd_mux;
   logic [31:0]                 prdata_r;
   logic                        err_r;

   // ==========================================================================
   // Field extraction helpers
   function automatic logic [spd_pkg::MAIN_W-1:0] main_of(
      input logic [spd_pkg::WORD_W-1:0] w);
      main_of = w[spd_pkg::MAIN_LSB +: spd_pkg::MAIN_W];
   endfunction

   function automatic logic [spd_pkg::SWALLOW_W-1:0] swallow_of(
      input logic [spd_pkg::WORD_W-1:0] w);
      swallow_of = w[spd_pkg::SWALLOW_LSB +: spd_pkg::SWALLOW_W];
   endfunction

   // ==========================================================================
   // Pin synchronisers: two flops, then a third for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_r <= PIN_IDLE;
         pin_sync_r <= PIN_IDLE;
         pin_prev_r <= PIN_IDLE;
      end else begin
         pin_meta_r <= {pol_raw, osc_in, vco_in, latch_transfer_strobe,
                        serial_data_in, serial_clk_in};
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   // Rising edges seen after synchronisation
   assign pin_rise = pin_sync_r & ~pin_prev_r;

   // Undriven select pin reads high through the pull-up
   assign pol_raw = phase_polarity_select_drv ? phase_polarity_select : 1'b1;

   // ==========================================================================
   // Serial shift register, first bit in ends up at the top (MSB first)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_r <= '0;
      end else if (ser_en_r && pin_rise[spd_pkg::PIN_SCLK]) begin
         shift_r <= {shift_r[spd_pkg::WORD_W-2:0],
                     pin_sync_r[spd_pkg::PIN_SDATA]};
      end
   end

   // ==========================================================================
   // Setting latch: transparent while the strobe is high, takes setword_r on a software load, holds otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_r <= {spd_pkg::MAIN_RESET, spd_pkg::SWALLOW_RESET};
      end else if (pin_sync_r[spd_pkg::PIN_LTS]) begin
         latch_r <= shift_r;
      end else if (sw_load) begin
         latch_r <= setword_r;
      end
   end
   // Only the strobe or a software load writes latch_r; serial edges never do

   // Straight binary fields, bit 0 least significant
   assign main_count_bits    = main_of(latch_r);
   assign swallow_count_bits = swallow_of(latch_r);

   // Polarity select after synchronisation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pol_r <= 1'b1;
      end else begin
         pol_r <= pin_sync_r[spd_pkg::PIN_POL];
      end
   end

   // ==========================================================================
   // Reference divider: fixed 1 x 512 with no swallow
   spd_pulse_swallow u_ref_div (
      .clk           (pclk),
      .rst_n         (presetn),
      .in_pulse      (pin_rise[spd_pkg::PIN_OSC]),
      .main_count    (spd_pkg::REF_MAIN_COUNT),
      .swallow_count (spd_pkg::REF_SWALLOW),
      .out_pulse     (reference_compare_rate)
   );

   // Programmable divider: 512 x main + 16 x swallow
   spd_pulse_swallow u_vco_div (
      .clk           (pclk),
      .rst_n         (presetn),
      .in_pulse      (pin_rise[spd_pkg::PIN_VCO]),
      .main_count    (main_count_bits),
      .swallow_count (swallow_count_bits),
      .out_pulse     (vco_compare_rate)
   );

   // ==========================================================================
   // Phase/frequency detector terms
   assign abl_active = (abl_cnt_r != '0);
   assign up_set     = up_r | reference_compare_rate;
   assign dn_set     = dn_r | vco_compare_rate;
   assign abl_start  = !abl_active && up_set && dn_set;

   // Up and down flags; both set starts a short spike window then clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_r      <= 1'b0;
         dn_r      <= 1'b0;
         abl_cnt_r <= '0;
      end else if (abl_active) begin
         abl_cnt_r <= abl_cnt_r - 3'h1;
         if (abl_cnt_r == 3'h1) begin
            up_r <= reference_compare_rate;  // A pulse in the clear cycle wins
            dn_r <= vco_compare_rate;
         end
      end else begin
         up_r <= up_set;                       // Extra edges saturate
         dn_r <= dn_set;
         if (abl_start) begin
            abl_cnt_r <= spd_pkg::ABL_CYCLES;
         end
      end
   end

   // ==========================================================================
   // Charge pump drive: at zero error spike high then low with select high, low then high with select low, else up/down
   assign cp_drive = abl_active || (up_r ^ dn_r);
   assign cp_level = abl_active ? ((abl_cnt_r == spd_pkg::ABL_CYCLES) ~^ pol_r)
                                : (up_r ~^ pol_r);

   // Registered pump, lock and monitor outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cp_out_r <= 1'b0;
         cp_oe_r  <= 1'b0;
         lock_r   <= 1'b1;
         mon_r    <= 1'b0;
      end else begin
         cp_out_r <= cp_drive & cp_level;
         cp_oe_r  <= cp_drive;
         lock_r   <= abl_active || !(up_r ^ dn_r);
         mon_r    <= pol_r ? reference_compare_rate
                           : vco_compare_rate;
      end
   end

   // Both pump pins carry the same drive
   assign charge_pump_out_one    = cp_out_r;
   assign charge_pump_out_one_oe = cp_oe_r;
   assign charge_pump_out_two    = cp_out_r;
   assign charge_pump_out_two_oe = cp_oe_r;
   assign lock_indicator         = lock_r;
   assign monitor_out            = mon_r;

   // ==========================================================================
   // APB decode
   assign setup_ph    = psel && !penable;
   assign access_ph   = psel && penable;
   assign sel_ctrl    = (paddr == spd_pkg::OFF_CTRL);
   assign sel_setword = (paddr == spd_pkg::OFF_SETWORD);
   assign sel_shift   = (paddr == spd_pkg::OFF_SHIFT);
   assign sel_latch   = (paddr == spd_pkg::OFF_LATCH);
   assign sel_status  = (paddr == spd_pkg::OFF_STATUS);
   assign addr_hit    = sel_ctrl | sel_setword | sel_shift | sel_latch | sel_status;
   assign wr_access   = access_ph && pwrite;
   assign sw_load     = wr_access && sel_ctrl && pwdata[spd_pkg::CTRL_SW_LOAD];

   // Read data selection, unused bits zero
   assign rd_mux = sel_ctrl    ? {31'h0000_0000, ser_en_r} :
                   sel_setword ? {18'h00000, setword_r} :
                   sel_shift   ? {18'h00000, shift_r} :
                   sel_latch   ? {18'h00000, latch_r} :
                   sel_status  ? {28'h000_0000, pol_r, dn_r, up_r, lock_r} :
                                 32'h0000_0000;

   // Software registers, written in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ser_en_r  <= spd_pkg::CTRL_SER_EN_RESET;
         setword_r <= {spd_pkg::MAIN_RESET, spd_pkg::SWALLOW_RESET};
      end else if (wr_access && sel_ctrl) begin
         ser_en_r <= pwdata[spd_pkg::CTRL_SER_EN];
      end else if (wr_access && sel_setword) begin
         setword_r <= pwdata[spd_pkg::WORD_W-1:0];
      end
   end

   // Read data and error captured in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
         err_r    <= 1'b0;
      end else if (setup_ph) begin
         prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
         err_r    <= !addr_hit || (pwrite && (sel_shift || sel_latch || sel_status));
      end
   end

   // Zero-wait access phase
   assign pready  = 1'b1;
   assign prdata  = prdata_r;
   assign pslverr = access_ph && err_r;

endmodule

// [logic/spd_pkg.sv]
// Purpose: Shared constants of the serial-programmed divider and phase detector core
// Assumes: One 32-bit APB register window, 200 MHz pclk
// Notes:   Word layout, divider ratios and register offsets live here only
package spd_pkg;

   // ==========================================================================
   // Setting word layout
   localparam int unsigned WORD_W      = 14;
   localparam int unsigned SWALLOW_W   = 5;
   localparam int unsigned MAIN_W      = 9;
   localparam int unsigned SWALLOW_LSB = 0;
   localparam int unsigned MAIN_LSB    = 5;

   // ==========================================================================
   // Divider ratios (total = 512 * main + 16 * swallow)
   localparam int unsigned PRE_W          = 10;
   localparam logic [9:0]  PRE_MOD_LOW    = 10'h200;  // 512
   localparam logic [9:0]  PRE_MOD_HIGH   = 10'h210;  // 528
   localparam logic [8:0]  REF_MAIN_COUNT = 9'h001;   // Reference: 1 x 512
   localparam logic [4:0]  REF_SWALLOW    = 5'h00;
   localparam logic [8:0]  MAIN_RESET     = 9'h020;   // 32, lowest legal main count
   localparam logic [4:0]  SWALLOW_RESET  = 5'h00;

   // ==========================================================================
   // Phase detector timing
   localparam int unsigned ABL_W          = 3;
   localparam logic [2:0]  ABL_CYCLES     = 3'h2;     // Spike length at zero error

   // ==========================================================================
   // APB register map (byte addresses)
   localparam logic [7:0]  OFF_CTRL    = 8'h00;
   localparam logic [7:0]  OFF_SETWORD = 8'h04;
   localparam logic [7:0]  OFF_SHIFT   = 8'h08;
   localparam logic [7:0]  OFF_LATCH   = 8'h0C;
   localparam logic [7:0]  OFF_STATUS  = 8'h10;

   // CTRL fields
   localparam int unsigned CTRL_SER_EN  = 0;
   localparam int unsigned CTRL_SW_LOAD = 1;
   localparam logic        CTRL_SER_EN_RESET = 1'b1;

   // STATUS fields
   localparam int unsigned ST_LOCK = 0;
   localparam int unsigned ST_UP   = 1;
   localparam int unsigned ST_DOWN = 2;
   localparam int unsigned ST_POL  = 3;

   // Pin synchroniser slots
   localparam int unsigned PIN_N     = 6;
   localparam int unsigned PIN_SCLK  = 0;
   localparam int unsigned PIN_SDATA = 1;
   localparam int unsigned PIN_LTS   = 2;
   localparam int unsigned PIN_VCO   = 3;
   localparam int unsigned PIN_OSC   = 4;
   localparam int unsigned PIN_POL   = 5;

endpackage

// [logic/spd_pulse_swallow.sv]
// Purpose: Dual-modulus prescaler with swallow and main counters
// Assumes: in_pulse is a one-cycle pulse per input edge, swallow <= main
// Notes:   New counts are taken at the reload that ends each output period
`timescale 1ns/1ps
module spd_pulse_swallow (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // Input edges and counts
   input  wire logic                         in_pulse,
   input  wire logic [spd_pkg::MAIN_W-1:0]   main_count,
   input  wire logic [spd_pkg::SWALLOW_W-1:0] swallow_count,
   // Divided output
   output logic                              out_pulse
);

   logic [spd_pkg::PRE_W-1:0]     pre_cnt_r;
   logic [spd_pkg::MAIN_W-1:0]    main_left_r;
   logic [spd_pkg::SWALLOW_W-1:0] swallow_left_r;
   logic [spd_pkg::PRE_W-1:0]     pre_mod;
   logic                          pre_wrap;
   logic                          period_end;

   // ==========================================================================
   // Modulus select: 528 while swallow pulses remain, else 512
   assign pre_mod    = (swallow_left_r != '0) ? spd_pkg::PRE_MOD_HIGH
                                              : spd_pkg::PRE_MOD_LOW;
   assign pre_wrap   = in_pulse && (pre_cnt_r == pre_mod - 10'h001);
   assign period_end = pre_wrap && (main_left_r <= 9'h001);

   // ==========================================================================
   // Prescaler, swallow and main counters
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_r      <= '0;
         main_left_r    <= 9'h001;
         swallow_left_r <= '0;
         out_pulse      <= 1'b0;
      end else begin
         out_pulse <= period_end;
         if (in_pulse) begin
            pre_cnt_r <= pre_wrap ? '0 : pre_cnt_r + 10'h001;
         end
         if (period_end) begin
            // Reload: N prescaler periods, first A at 528 -> 512N + 16A
            main_left_r    <= main_count;
            swallow_left_r <= swallow_count;
         end else if (pre_wrap) begin
            main_left_r <= main_left_r - 9'h001;
            if (swallow_left_r != '0) begin
               swallow_left_r <= swallow_left_r - 5'h01;
            end
         end
      end
   end

endmodule

// [sim/spd_core_monitor.sv]
// Purpose: Concurrent checks on the synthesizer core ports
// Assumes: One pclk domain, presetn asynchronous active low
// Notes:   Spike checks assume divider pulses far apart from each other
`timescale 1ns/1ps
module spd_core_monitor (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   // Pump, lock and monitor
   input wire logic        charge_pump_out_one,
   input wire logic        charge_pump_out_one_oe,
   input wire logic        charge_pump_out_two,
   input wire logic        charge_pump_out_two_oe,
   input wire logic        lock_indicator,
   input wire logic        monitor_out
);
   // ==========================================================================
   // Clocking and spike window
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic spike = charge_pump_out_one_oe & lock_indicator;

   // ==========================================================================
   // Assertions
   a_pump_pair: assert property (
      charge_pump_out_one_oe == charge_pump_out_two_oe && charge_pump_out_one == charge_pump_out_two)
      else $error("Pump pins disagree");
   a_unlock_drives: assert property (!lock_indicator |-> charge_pump_out_one_oe)
      else $error("Unlocked without pump drive");
   a_lock_at_spike: assert property ($rose(lock_indicator) |-> charge_pump_out_one_oe)
      else $error("Lock regained outside a spike");
   a_spike_shape: assert property ($rose(spike) |=>
      spike && charge_pump_out_one != $past(charge_pump_out_one) ##1 !charge_pump_out_one_oe)
      else $error("Spike shape wrong");
   a_oe_end_locked: assert property (
      $fell(charge_pump_out_one_oe) |-> lock_indicator && $past(lock_indicator))
      else $error("Pump released while unlocked");
   a_monitor_pulse: assert property (monitor_out |=> !monitor_out [*8])
      else $error("Monitor pulse too long or too close");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("Slave error outside access phase");
   a_err_read_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
      else $error("Refused read returned data");
endmodule

bind spd_core spd_core_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
   .pslverr, .charge_pump_out_one, .charge_pump_out_one_oe, .charge_pump_out_two,
   .charge_pump_out_two_oe, .lock_indicator, .monitor_out);

// [sim/spd_host_model.sv]
// Purpose: Host controller model that loads setting words over the serial pins
// Assumes: 64 ns shift clock that idles low between frames
// Notes:   Once a frame ends the data pin shows the inverse of its last bit
`timescale 1ns/1ps
module spd_host_model (
   // Serial programming pins
   output logic serial_clk_in,
   output logic serial_data_in,
   output logic latch_transfer_strobe
);
   // ==========================================================================
   // Idle levels
   initial begin
      serial_clk_in = 1'b0;
      serial_data_in = 1'b0;
      latch_transfer_strobe = 1'b0;
   end

   // ==========================================================================
   // Sixteen bits, most significant first; the oldest two fall out the far end
   task automatic send(input logic [15:0] w, input logic latch);
      for (int i = 15; i >= 0; i--) begin
         serial_data_in = w[i];
         #16 serial_clk_in = 1'b1;
         #32 serial_clk_in = 1'b0;
         #16;
      end
      if (latch) begin
         #32 latch_transfer_strobe = 1'b1;
         #40 latch_transfer_strobe = 1'b0;
      end
      serial_data_in = ~w[0];
   endtask
endmodule

// [sim/tb_serial_pll_divider_phase_detect.sv]
// Purpose: Self-checking bench of the synthesizer core over APB and serial pins
// Assumes: 200 MHz pclk, rate pins made on pclk edges
// Notes:   Small divider counts keep the run short
`timescale 1ns/1ps
module tb_serial_pll_divider_phase_detect;
   // ==========================================================================
   // Signals
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        serial_clk_in, serial_data_in, latch_transfer_strobe, vco_in, osc_in;
   logic        phase_polarity_select, phase_polarity_select_drv, lock_indicator, monitor_out;
   logic        charge_pump_out_one, charge_pump_out_one_oe, charge_pump_out_two;
   logic        charge_pump_out_two_oe;
   int          n_errors, checked, osc_half, vco_cnt, osc_cnt, osc_edges, vco_edges;
   wire logic   driving = charge_pump_out_one_oe & ~lock_indicator;
   wire logic   spike = charge_pump_out_one_oe & lock_indicator;

   // ==========================================================================
   // Design, host and clock
   spd_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .serial_clk_in, .serial_data_in, .latch_transfer_strobe, .vco_in,
      .osc_in, .phase_polarity_select, .phase_polarity_select_drv, .charge_pump_out_one,
      .charge_pump_out_one_oe, .charge_pump_out_two, .charge_pump_out_two_oe,
      .lock_indicator, .monitor_out);
   spd_host_model i_host (.serial_clk_in, .serial_data_in, .latch_transfer_strobe);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Rate pins toggle on pclk; rising edges are counted where they are made
   always @(posedge pclk) begin
      vco_cnt <= (vco_cnt >= 2) ? 0 : vco_cnt + 1;
      vco_in <= (vco_cnt >= 2) ? ~vco_in : vco_in;
      vco_edges <= vco_edges + ((vco_cnt >= 2 && !vco_in) ? 1 : 0);
      osc_cnt <= (osc_cnt >= osc_half - 1) ? 0 : osc_cnt + 1;
      osc_in <= (osc_cnt >= osc_half - 1) ? ~osc_in : osc_in;
      osc_edges <= osc_edges + ((osc_cnt >= osc_half - 1 && !osc_in) ? 1 : 0);
   end

   // ==========================================================================
   // Tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic e, string what);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
      chk(what, {31'h0, e}, {31'h0, err});
   endtask

   function automatic logic [31:0] mk(input int m, input int a);
      return 32'((m << spd_pkg::MAIN_LSB) | (a << spd_pkg::SWALLOW_LSB));
   endfunction

   task automatic send(input logic [15:0] w, input logic latch);
      i_host.send(w, latch);
      repeat (8) @(posedge pclk);
   endtask

   // Bounded wait for a monitor pulse, returning the edge counts at it
   task automatic wait_mon(output int ov, output int vv);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (monitor_out !== 1'b1 && k < 20000);
      chk("monitor pulse seen", 32'h1, {31'h0, monitor_out});
      ov = osc_edges;
      vv = vco_edges;
   endtask

   task automatic meas(input bit use_ref, input int exp, input string what);
      int o0, v0, o1, v1;
      wait_mon(o0, v0);
      wait_mon(o0, v0);
      wait_mon(o1, v1);
      chk(what, exp, use_ref ? o1 - o0 : v1 - v0);
   endtask

   // Optionally wait for a spike, then for the pump to drive, and check its level
   task automatic pump(input bit sp, input logic exp, input string what);
      int k;
      k = 0;
      repeat (8) @(posedge pclk);
      while (sp && spike !== 1'b1 && k < 30000) begin
         @(posedge pclk);
         k++;
      end
      while (driving !== 1'b1 && k < 60000) begin
         @(posedge pclk);
         k++;
      end
      chk(what, {31'h0, exp}, {31'h0, charge_pump_out_one});
   endtask

   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==========================================================================
   // Watchdog
   initial begin
      #(95000 * 5);
      n_errors++;
      $display("Error watchdog expected completion seen timeout");
      complete_run();
   end

   // ==========================================================================
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {vco_in, osc_in, phase_polarity_select, phase_polarity_select_drv} = '0;
      {n_errors, checked, vco_cnt, osc_cnt, osc_edges, vco_edges} = '0;
      osc_half = 4;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("lock after reset", 32'h1, {31'h0, lock_indicator});
      rchk(spd_pkg::OFF_CTRL, 32'h1, 1'b0, "ctrl reset");
      rchk(spd_pkg::OFF_SETWORD, mk(32, 0), 1'b0, "setword reset");
      rchk(8'h14, 32'h0, 1'b1, "unmapped read");
      apb(1'b1, spd_pkg::OFF_LATCH, 32'h3FFF);
      chk("latch write refused", 32'h1, {31'h0, err});
      apb(1'b0, spd_pkg::OFF_STATUS, 32'h0);
      chk("open select reads high", 32'h1, {31'h0, rd[spd_pkg::ST_POL]});
      send(16'hABCD, 1'b0);
      rchk(spd_pkg::OFF_SHIFT, 32'h2BCD, 1'b0, "shift order");
      rchk(spd_pkg::OFF_LATCH, mk(32, 0), 1'b0, "latch held");
      send(16'(mk(511, 31)), 1'b1);
      rchk(spd_pkg::OFF_LATCH, 32'h3FFF, 1'b0, "latch all ones");
      apb(1'b1, spd_pkg::OFF_CTRL, 32'h0);
      send(16'h1555, 1'b0);
      rchk(spd_pkg::OFF_SHIFT, 32'h3FFF, 1'b0, "shift while disabled");
      apb(1'b1, spd_pkg::OFF_SETWORD, mk(40, 3));
      apb(1'b1, spd_pkg::OFF_CTRL, 32'h3);
      rchk(spd_pkg::OFF_LATCH, mk(40, 3), 1'b0, "software load");
      rchk(spd_pkg::OFF_CTRL, 32'h1, 1'b0, "ctrl after load");
      send(16'(mk(2, 1)), 1'b1);
      rchk(spd_pkg::OFF_LATCH, mk(2, 1), 1'b0, "small setting");
      pump(1'b1, 1'b1, "pump up select high");
      meas(1'b1, 512, "reference division");
      phase_polarity_select_drv <= 1'b1;
      meas(1'b0, 512 * 2 + 16 * 1, "vco division");
      pump(1'b0, 1'b0, "pump up select low");
      phase_polarity_select_drv <= 1'b0;
      pump(1'b0, 1'b1, "pump up select open");
      osc_half <= 12;
      repeat (13000) @(posedge pclk);
      pump(1'b1, 1'b0, "pump down select high");
      complete_run();
   end
endmodule
